// [include/uptc_pkg.sv]
// package for the usb phy tuning and express capability register bank
package uptc_pkg;

   // ------------------------------------------------------------------
   // register offsets (configuration space byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] UPTC_OFS_PHY_TUNE = 8'hAC;
   localparam logic [7:0] UPTC_OFS_CAP_HDR = 8'hE0;

   // ------------------------------------------------------------------
   // usb port phy tuning word
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] rsvd;        // 31:24
      logic [1:0] pre_emph;    // 23:22
      logic [1:0] ls_rise_fall; // 21:20
      logic [1:0] fs_rise_fall; // 19:18
      logic [1:0] pll_cp_cur;  // 17:16
      logic [2:0] cal_ref;     // 15:13
      logic [1:0] squelch_ref; // 12:11
      logic [1:0] disc_ref;    // 10:9
      logic [3:0] hs_slope;    // 8:5
      logic [1:0] hs_amp;      // 4:3
      logic [1:0] nmos_str;    // 2:1
      logic pmos_str;          // 0
   } uptc_phy_tune_s;

   localparam logic PHY_PMOS_RST = 1'h0;
   localparam logic [1:0] PHY_NMOS_RST = 2'h0;
   localparam logic [1:0] PHY_AMP_RST = 2'h0;
   localparam logic [3:0] PHY_SLOPE_RST = 4'h0;
   localparam logic [1:0] PHY_DISC_RST = 2'h2;
   localparam logic [1:0] PHY_SQ_RST = 2'h2;
   localparam logic [2:0] PHY_CAL_RST = 3'h4;
   localparam logic [1:0] PHY_CP_RST = 2'h0;
   localparam logic [1:0] PHY_FS_RST = 2'h1;
   localparam logic [1:0] PHY_LS_RST = 2'h1;
   localparam logic [1:0] PHY_PRE_RST = 2'h0;
   localparam logic [7:0] PHY_RSVD_VAL = 8'h00;
   localparam logic [31:0] PHY_LOAD_MASK = 32'h00FF_FFFF;

   // ------------------------------------------------------------------
   // express capability header word
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rsvd;        // 31:30
      logic [4:0] int_msg_num; // 29:25
      logic slot_impl;         // 24
      logic [3:0] port_type;   // 23:20
      logic [3:0] cap_version; // 19:16
      logic [7:0] next_ptr;    // 15:8
      logic [7:0] cap_id;      // 7:0
   } uptc_cap_hdr_s;

   localparam logic [7:0] CAP_ID_RST = 8'h10;
   localparam logic [7:0] CAP_NEXT_RST = 8'h00;
   localparam logic [3:0] CAP_VER_RST = 4'h1;
   localparam logic [3:0] CAP_TYPE_RST = 4'h1;
   localparam logic CAP_SLOT_VAL = 1'h0;
   localparam logic [4:0] CAP_INTMSG_VAL = 5'h00;
   localparam logic [1:0] CAP_RSVD_VAL = 2'h0;
   localparam logic [31:0] CAP_LOAD_MASK = 32'h00FF_FFFF;

   // ------------------------------------------------------------------
   // access request carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } uptc_cfg_req_s;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
   } uptc_load_req_s;

endpackage

// [hdl/uptc_regs.sv]
// usb port phy tuning and express capability header register bank
//
// Operation
// - tuning and header fields read-only to host; loader may replace defaults
// - pmos strength resets to 0, nmos strength bits 2:1 reset to 00
// - amplitude bits 4:3 reset to zero, slope bits 8:5 reset to 0000
// - disconnect and squelch reference fields each reset to binary 10
// - calibration reference bits 15:13 reset to binary 100
// - pll charge pump and pre-emphasis fields each reset to 00
// - full-speed and low-speed rise/fall fields each reset to 01
// - capability identifier byte reads 10h unless loader replaced it
// - next capability pointer resets and reads as 00h unless loader replaced it
// - capability version reads as 0001b unless loader replaced it
// - device/port type resets to 1h, legacy endpoint
// - slot-implemented bit and interrupt message number hardwired to zero
`timescale 1ns/1ps
module uptc_regs (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // host configuration access
   input uptc_pkg::uptc_cfg_req_s cfg_req_in,
   output logic [31:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   // smbus / eeprom loader writes
   input uptc_pkg::uptc_load_req_s load_req_in,
   // analog phy tuning
   output uptc_pkg::uptc_phy_tune_s phy_tune_out
);
   import uptc_pkg::*;

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   uptc_phy_tune_s phy_q, phy_d;
   uptc_cap_hdr_s cap_q, cap_d;
   logic [31:0] rdata_q;
   logic rvalid_q;

   localparam uptc_phy_tune_s PHY_RST = '{
      rsvd: PHY_RSVD_VAL, pre_emph: PHY_PRE_RST, ls_rise_fall: PHY_LS_RST,
      fs_rise_fall: PHY_FS_RST, pll_cp_cur: PHY_CP_RST, cal_ref: PHY_CAL_RST,
      squelch_ref: PHY_SQ_RST, disc_ref: PHY_DISC_RST, hs_slope: PHY_SLOPE_RST,
      hs_amp: PHY_AMP_RST, nmos_str: PHY_NMOS_RST, pmos_str: PHY_PMOS_RST};

   localparam uptc_cap_hdr_s CAP_RST = '{
      rsvd: CAP_RSVD_VAL, int_msg_num: CAP_INTMSG_VAL, slot_impl: CAP_SLOT_VAL,
      port_type: CAP_TYPE_RST, cap_version: CAP_VER_RST, next_ptr: CAP_NEXT_RST,
      cap_id: CAP_ID_RST};

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   wire logic load_phy = load_req_in.wr && (load_req_in.addr == UPTC_OFS_PHY_TUNE);
   wire logic load_cap = load_req_in.wr && (load_req_in.addr == UPTC_OFS_CAP_HDR);
   wire logic hit_phy = cfg_req_in.addr == UPTC_OFS_PHY_TUNE;
   wire logic hit_cap = cfg_req_in.addr == UPTC_OFS_CAP_HDR;

   // loader replaces defaults
   // hardwired bits above the mask never take loader data
   assign phy_d = load_phy ?
      uptc_phy_tune_s'((load_req_in.data & PHY_LOAD_MASK) | (PHY_RST & ~PHY_LOAD_MASK))
      : phy_q;
   assign cap_d = load_cap ?
      uptc_cap_hdr_s'((load_req_in.data & CAP_LOAD_MASK) | (CAP_RST & ~CAP_LOAD_MASK))
      : cap_q;

   // host writes ignored
   // cfg_req_in.wr and wdata are deliberately not decoded into storage
   wire logic [31:0] rd_mux = hit_phy ? 32'(phy_q) : (hit_cap ? 32'(cap_q) : 32'h0000_0000);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // tuning defaults at reset
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         phy_q <= PHY_RST;
         cap_q <= CAP_RST;
      end else begin
         phy_q <= phy_d;
         cap_q <= cap_d;
      end
   end

   // read answer one cycle after the request; unmapped offsets read zero
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= cfg_req_in.rd;
         rdata_q <= cfg_req_in.rd ? rd_mux : rdata_q;
      end
   end

   assign cfg_rdata_out = rdata_q;
   assign cfg_rvalid_out = rvalid_q;
   assign phy_tune_out = phy_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   sequence s_in_reset;
      !rst_n_in;
   endsequence

   sequence s_phy_load;
      load_phy ##1 (phy_q == uptc_phy_tune_s'(($past(load_req_in.data) & PHY_LOAD_MASK)));
   endsequence

   sequence s_cap_load;
      load_cap ##1 (cap_q == uptc_cap_hdr_s'(($past(load_req_in.data) & CAP_LOAD_MASK)));
   endsequence

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   // strength defaults
   AST_PHY_DRIVE_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> (phy_tune_out.pmos_str == PHY_PMOS_RST)
                     && (phy_tune_out.nmos_str == PHY_NMOS_RST))
      else $error("driver strength reset value wrong");
   AST_AMP_SLOPE_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> (phy_q.hs_amp == PHY_AMP_RST) && (phy_q.hs_slope == PHY_SLOPE_RST))
      else $error("amplitude or slope reset value wrong");
   AST_REF_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> (phy_q.disc_ref == PHY_DISC_RST) && (phy_q.squelch_ref == PHY_SQ_RST))
      else $error("disconnect or squelch reference reset wrong");
   AST_CAL_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> phy_q.cal_ref == PHY_CAL_RST)
      else $error("calibration reference reset wrong");
   AST_CP_PRE_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> (phy_q.pll_cp_cur == PHY_CP_RST) && (phy_q.pre_emph == PHY_PRE_RST))
      else $error("charge pump or pre-emphasis reset wrong");
   AST_RISE_FALL_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> (phy_q.fs_rise_fall == PHY_FS_RST) && (phy_q.ls_rise_fall == PHY_LS_RST))
      else $error("rise/fall control reset wrong");
   AST_NEXT_PTR_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> cap_q.next_ptr == CAP_NEXT_RST)
      else $error("next pointer reset wrong");
   AST_VERSION_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> cap_q.cap_version == CAP_VER_RST)
      else $error("capability version reset wrong");
   AST_TYPE_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> cap_q.port_type == CAP_TYPE_RST)
      else $error("port type reset wrong");
   AST_RD_PORT_RST: assert property (@(posedge core_clk_in)
      s_in_reset |=> !cfg_rvalid_out && (cfg_rdata_out == '0))
      else $error("read port not cleared by reset");

   // ------------------------------------------------------------------
   // loader path
   // ------------------------------------------------------------------
   // tuning word load
   AST_LOAD_PHY: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      load_phy |-> s_phy_load)
      else $error("loader write did not reach tuning word");
   AST_LOAD_CAP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      load_cap |-> s_cap_load)
      else $error("loader write did not reach header word");
   AST_PHY_TOP_FIXED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      load_phy |=> phy_q.rsvd == PHY_RSVD_VAL)
      else $error("loader reached unused tuning bits");
   AST_HARDWIRED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      load_cap |=> (cap_q.slot_impl == CAP_SLOT_VAL) && (cap_q.rsvd == CAP_RSVD_VAL)
                   && (cap_q.int_msg_num == CAP_INTMSG_VAL))
      else $error("hardwired header bits changed");
   AST_LOAD_OTHER_IGNORED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (load_req_in.wr && !load_phy && !load_cap)
      |=> $stable(phy_q) && $stable(cap_q))
      else $error("load to another offset altered a register");

   // ------------------------------------------------------------------
   // host access path
   // ------------------------------------------------------------------
   // first header read
   AST_CAP_ID_READ: assert property (@(posedge core_clk_in)
      s_in_reset ##1 (rst_n_in && !load_cap && cfg_req_in.rd && hit_cap)
      |=> cfg_rvalid_out && (cfg_rdata_out[7:0] == CAP_ID_RST))
      else $error("capability_identifier did not read default");
   AST_HOST_WR_IGNORED: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (cfg_req_in.wr && !load_req_in.wr) |=> $stable(phy_q) && $stable(cap_q))
      else $error("host write altered a read-only register");
   AST_READ_DATA: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (cfg_req_in.rd && hit_phy && !load_phy) |=> cfg_rvalid_out
                                                  && (cfg_rdata_out == 32'(phy_tune_out)))
      else $error("tuning word read data mismatch");
   AST_CAP_READ_DATA: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (cfg_req_in.rd && hit_cap && !load_cap) |=> cfg_rvalid_out
                                                  && (cfg_rdata_out == 32'(cap_q)))
      else $error("header word read data mismatch");
   AST_UNMAPPED_ZERO: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (cfg_req_in.rd && !hit_phy && !hit_cap) |=> cfg_rvalid_out && (cfg_rdata_out == '0))
      else $error("unmapped offset did not read zero");
   AST_RVALID_PULSE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !cfg_req_in.rd |=> !cfg_rvalid_out)
      else $error("read answer without a read");
   AST_RDATA_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !cfg_req_in.rd |=> $stable(cfg_rdata_out))
      else $error("read data changed without a read");

endmodule // uptc_regs

// [verif/uptc_loader_model.sv]
// smbus / eeprom loader model that replaces register defaults
`timescale 1ns/1ps
module uptc_loader_model (
   // clock
   input wire logic core_clk_in,
   // loader writes
   output uptc_pkg::uptc_load_req_s load_req_out
);
   import uptc_pkg::*;
   initial load_req_out = '0;
   // ------------------------------------------------------------------
   // one full-word write, driven off the falling edge
   // ------------------------------------------------------------------
   // default replacement write
   task automatic load(input logic [7:0] addr, input logic [31:0] data);
      @(negedge core_clk_in);
      load_req_out = '{wr: 1'b1, addr: addr, data: data};
      @(negedge core_clk_in);
      // released lines show inverted data so stale values never look valid
      load_req_out = '{wr: 1'b0, addr: ~addr, data: ~data};
   endtask
endmodule // uptc_loader_model

// [verif/uptc_regs_tb.sv]
// self-checking bench for the phy tuning and capability register bank
`timescale 1ns/1ps
module uptc_regs_tb;
   import uptc_pkg::*;
   localparam logic [31:0] PHY_DEF = 32'h0014_9400;
   localparam logic [31:0] CAP_DEF = 32'h0011_0010;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   uptc_cfg_req_s cfg_req = '0;
   uptc_load_req_s load_req;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid;
   uptc_phy_tune_s phy_tune;
   int fail_count = 0;
   int samples_checked = 0;
   always #20 core_clk_in = ~core_clk_in;
   uptc_regs dut (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .cfg_req_in(cfg_req),
      .cfg_rdata_out(cfg_rdata),
      .cfg_rvalid_out(cfg_rvalid),
      .load_req_in(load_req),
      .phy_tune_out(phy_tune)
   );
   uptc_loader_model ldr (
      .core_clk_in(core_clk_in),
      .load_req_out(load_req)
   );
   // ------------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // called at a falling edge; leaves rd high so reads can run back to back
   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      cfg_req = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 32'h0000_0000};
      @(negedge core_clk_in);
      cmp({31'h0000_0000, cfg_rvalid}, 32'h0000_0001);
      cmp(cfg_rdata, exp);
   endtask
   task automatic wr_host(input logic [7:0] addr, input logic [31:0] data);
      cfg_req = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
      @(negedge core_clk_in);
   endtask
   task automatic idle;
      cfg_req = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 32'h0000_0000};
      @(negedge core_clk_in);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      repeat (5) @(negedge core_clk_in);
      cmp(phy_tune, PHY_DEF);
      rst_n_in = 1'b1;
      @(negedge core_clk_in);
      rd_chk(UPTC_OFS_PHY_TUNE, PHY_DEF);
      rd_chk(UPTC_OFS_CAP_HDR, CAP_DEF);
      rd_chk(8'h94, 32'h0000_0000);
      idle();
      cmp({31'h0000_0000, cfg_rvalid}, 32'h0000_0000);
      $display("test reset_defaults done");
      wr_host(UPTC_OFS_PHY_TUNE, 32'hFFFF_FFFF);
      wr_host(UPTC_OFS_CAP_HDR, 32'h0000_0000);
      idle();
      cmp(phy_tune, PHY_DEF);
      rd_chk(UPTC_OFS_PHY_TUNE, PHY_DEF);
      rd_chk(UPTC_OFS_CAP_HDR, CAP_DEF);
      idle();
      $display("test host_write_ignored done");
      ldr.load(UPTC_OFS_PHY_TUNE, 32'hFFFF_FFFF);
      cmp(phy_tune, 32'h00FF_FFFF);
      ldr.load(UPTC_OFS_PHY_TUNE, 32'h5AA5_3CC3);
      cmp(phy_tune, 32'h00A5_3CC3);
      ldr.load(UPTC_OFS_CAP_HDR, 32'hFFFF_FFFF);
      rd_chk(UPTC_OFS_CAP_HDR, 32'h00FF_FFFF);
      rd_chk(UPTC_OFS_PHY_TUNE, 32'h00A5_3CC3);
      idle();
      cmp(cfg_rdata, 32'h00A5_3CC3);
      // a load to an offset outside the bank must leave the tuning word alone
      ldr.load(8'h94, 32'hFFFF_FFFF);
      cmp(phy_tune, 32'h00A5_3CC3);
      $display("test loader_replace done");
      rst_n_in = 1'b0;
      @(negedge core_clk_in);
      cmp(phy_tune, PHY_DEF);
      // first read taken at the first edge out of reset
      rst_n_in = 1'b1;
      rd_chk(UPTC_OFS_CAP_HDR, CAP_DEF);
      idle();
      $display("test second_reset done");
      report_and_stop();
   end
   // hang guard, well beyond the few dozen cycles the tests need
   initial begin
      #20000;
      fail_count++;
      report_and_stop();
   end
endmodule // uptc_regs_tb
